// ### hw/lst_trim_regs.sv
// axi4-lite register bank holding lcd supply trim codes and bandgap enable
// assumes a synchronous active-high reset and a standby level from a pin
// Summary of operation
// - coarse code bits 7..4, reset zero
// - coarse code meaning is analog side only
// - drive trim bit 3 reads one
// - fine code bits 2..0, reset zero
// - fine code meaning is analog side only
// - bandgap enable bit 7, reset zero
// - bandgap bits 6..3 read ones
// - bandgap trim bits 2..0, reset zero
// - supply off unless enabled and awake
module lst_trim_regs (
   input  wire logic                          clock,
   input  wire logic                          reset,
   input  wire logic [lst_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [lst_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          standby,
   output logic [lst_pkg::COARSE_W-1:0]       coarse_trim_code,
   output logic [lst_pkg::FINE_W-1:0]         fine_trim_code,
   output logic                               bandgap_run_enable,
   output logic [lst_pkg::BG_TRIM_W-1:0]      bandgap_trim_code,
   output logic                               supply_on
);
   import lst_pkg::*;

   // ------------------------------------------------------------
   // write channel capture
   // ------------------------------------------------------------
   logic                aw_held;
   logic [ADDR_W-1:0]   aw_addr;
   logic                w_held;
   logic [31:0]         w_data;
   logic                w_lane0;
   logic                bvalid_q;
   logic [1:0]          bresp_q;

   wire aw_take  = s_axi_awvalid && s_axi_awready;
   wire w_take   = s_axi_wvalid && s_axi_wready;
   wire have_aw  = aw_held || aw_take;
   wire have_w   = w_held || w_take;
   wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0]  wr_data  = w_held ? w_data : s_axi_wdata;
   wire         wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
   wire do_write = have_aw && have_w && !bvalid_q;
   wire wr_en    = do_write && wr_lane0;
   wire hit_drv  = wr_addr == OFS_DRIVE_TRIM;
   wire hit_bg   = wr_addr == OFS_BANDGAP_CTL;
   wire hit_sup  = wr_addr == OFS_SUPPLY_CTL;
   wire wr_hit   = hit_drv || hit_bg || hit_sup;

   assign s_axi_awready = !aw_held && !bvalid_q;
   assign s_axi_wready  = !w_held && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   always_ff @(posedge clock) begin
      if (reset || do_write) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
      end else begin
         if (aw_take) aw_held <= 1'b1;
         if (w_take) w_held <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) begin
         w_data  <= s_axi_wdata;
         w_lane0 <= s_axi_wstrb[0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // stored trim codes
   // ------------------------------------------------------------
   logic supply_on_control;

   always_ff @(posedge clock) begin
      if (reset) begin
         coarse_trim_code <= COARSE_RST;
         fine_trim_code   <= FINE_RST;
      end else if (wr_en && hit_drv) begin
         coarse_trim_code <= wr_data[COARSE_LSB +: COARSE_W];
         fine_trim_code   <= wr_data[FINE_LSB +: FINE_W];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         bandgap_run_enable <= BG_EN_RST;
         bandgap_trim_code  <= BG_TRIM_RST;
      end else if (wr_en && hit_bg) begin
         bandgap_run_enable <= wr_data[BG_EN_BIT];
         bandgap_trim_code  <= wr_data[BG_TRIM_LSB +: BG_TRIM_W];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) supply_on_control <= SUPPLY_ON_RST;
      else if (wr_en && hit_sup) supply_on_control <= wr_data[SUPPLY_ON_BIT];
   end

   // ------------------------------------------------------------
   // standby pin synchroniser and supply gate
   // ------------------------------------------------------------
   logic [SYNC_STAGES-1:0] standby_sync;
   logic                   standby_level;

   always_ff @(posedge clock) begin
      if (reset) standby_sync <= '0;
      else standby_sync <= {standby_sync[SYNC_STAGES-2:0], standby};
   end

   wire standby_agree = standby_sync[2] == standby_sync[1];

   always_ff @(posedge clock) begin
      if (reset) standby_level <= 1'b0;
      else if (standby_agree) standby_level <= standby_sync[2];
   end

   wire next_supply_on = supply_on_control && bandgap_run_enable
                         && !standby_level;

   always_ff @(posedge clock) begin
      if (reset) supply_on <= 1'b0;
      else supply_on <= next_supply_on;
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire [7:0] drv_view = {coarse_trim_code, 1'b1, fine_trim_code};
   wire [7:0] bg_view  = {bandgap_run_enable, {BG_RSV_W{1'b1}},
                          bandgap_trim_code};
   wire rd_drv = s_axi_araddr == OFS_DRIVE_TRIM;
   wire rd_bg  = s_axi_araddr == OFS_BANDGAP_CTL;
   wire rd_sup = s_axi_araddr == OFS_SUPPLY_CTL;
   wire rd_hit = rd_drv || rd_bg || rd_sup;
   wire [31:0] rd_word = rd_drv ? {24'h0, drv_view} :
                         rd_bg  ? {24'h0, bg_view} :
                         rd_sup ? {30'h0, supply_on, supply_on_control} :
                                  32'h0;

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule

// ### include/lst_pkg.sv
// package for the lcd supply trim register bank
// assumes a 32-bit axi4-lite slave and one 125 MHz clock
package lst_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int          ADDR_W            = 4;
   localparam logic [3:0]  OFS_DRIVE_TRIM    = 4'h0;
   localparam logic [3:0]  OFS_BANDGAP_CTL   = 4'h4;
   localparam logic [3:0]  OFS_SUPPLY_CTL    = 4'h8;
   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int          COARSE_LSB        = 4;
   localparam int          COARSE_W          = 4;
   localparam int          FINE_LSB          = 0;
   localparam int          FINE_W            = 3;
   localparam int          DRIVE_RSV_BIT     = 3;
   localparam int          BG_EN_BIT         = 7;
   localparam int          BG_TRIM_LSB       = 0;
   localparam int          BG_TRIM_W         = 3;
   localparam int          BG_RSV_LSB        = 3;
   localparam int          BG_RSV_W          = 4;
   localparam int          SUPPLY_ON_BIT     = 0;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [3:0]  COARSE_RST        = 4'h0;
   localparam logic [2:0]  FINE_RST          = 3'h0;
   localparam logic [2:0]  BG_TRIM_RST       = 3'h0;
   localparam logic        BG_EN_RST         = 1'h0;
   localparam logic        SUPPLY_ON_RST     = 1'h0;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;
   // ------------------------------------------------------------
   // pin input synchroniser depth
   // ------------------------------------------------------------
   localparam int          SYNC_STAGES       = 3;
endpackage

// ### testbench/lst_trim_regs_monitor.sv
// assertions on bus handshakes and trim outputs of the trim register bank
// assumes a bind into lst_trim_regs; one clock, synchronous high reset
module lst_trim_regs_monitor (
   input logic        clock,
   input logic        reset,
   input logic        standby,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic [3:0]  coarse_trim_code,
   input logic [2:0]  fine_trim_code,
   input logic        bandgap_run_enable,
   input logic [2:0]  bandgap_trim_code,
   input logic        supply_on
);
   wire [10:0] trims = {coarse_trim_code, fine_trim_code,
                        bandgap_run_enable, bandgap_trim_code};
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   reset_zero_a: assert property ($past(reset) |->
      trims == 11'h000 && !supply_on) else $error("outputs not reset");
   trim_write_a: assert property ($changed(trims) |->
      $rose(s_axi_bvalid)) else $error("trim changed without write");
   supply_en_a: assert property (supply_on |->
      $past(bandgap_run_enable)) else $error("supply on while halted");
   standby_off_a: assert property (standby [*6] |->
      !supply_on) else $error("supply on in standby");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write response dropped");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read not answered");
   read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   cover property ($rose(supply_on));
   cover property ($rose(s_axi_bvalid));
   cover property ($changed(bandgap_trim_code));
endmodule
bind lst_trim_regs lst_trim_regs_monitor u_monitor (.*);

// ### testbench/tb_top.sv
// self-checking bench for the trim register bank over axi4-lite
// assumes lst_pkg and lst_trim_regs; 125 MHz clock
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lst_pkg::*;
   logic              clock = 1'h0;
   logic              reset = 1'h1;
   logic              standby = 1'h0;
   logic [3:0]        s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
   logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
   logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic              s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic              s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid, supply_on;
   logic              bandgap_run_enable;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic [3:0]        coarse_trim_code;
   logic [2:0]        fine_trim_code, bandgap_trim_code;
   int                error_cnt = 0, tests_run = 0, cyc = 0;
   lst_trim_regs dut (.*);
   initial forever #4 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [31:0] o();
      return {coarse_trim_code, fine_trim_code, bandgap_run_enable,
              bandgap_trim_code, supply_on};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] d,
                     input logic s = 1'h1);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= {4{s}};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      chk("bresp", (a > 4'h8) ? RESP_SLVERR : RESP_OKAY, s_axi_bresp);
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'h0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", (a > 4'h8) ? RESP_SLVERR : RESP_OKAY, s_axi_rresp);
   endtask
   task automatic t_drive();
      for (int i = 0; i < 16; i++) begin
         wr(4'h0, {i[3:0], 1'h0, i[2:0]});
         rc(4'h0, {i[3:0], 1'h1, i[2:0]});
         chk("outs", {i[3:0], i[2:0], 5'h00}, o());
      end
   endtask
   task automatic t_bandgap();
      for (int i = 0; i < 8; i++) begin
         wr(4'h4, {5'h10, i[2:0]});
         rc(4'h4, {5'h1f, i[2:0]});
         chk("outs", {8'hff, i[2:0], 1'h0}, o());
      end
   endtask
   task automatic t_supply();
      wr(4'h8, 8'h01);
      rc(4'h8, 32'h3);
      standby <= 1'h1;
      repeat (8) @(posedge clock);
      chk("supply_on", 1'h0, supply_on);
      standby <= 1'h0;
      repeat (8) @(posedge clock);
      chk("supply_on", 1'h1, supply_on);
      wr(4'h4, 8'h07);
      rc(4'h8, 32'h1);
   endtask
   task automatic t_odd();
      wr(4'hc, 8'hff);
      rc(4'hc, 32'h0);
      wr(4'h0, 8'h00, 1'h0);
      rc(4'h0, 32'hff);
   endtask
   task automatic t_reset();
      reset <= 1'h1;
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      chk("outs", 32'h0, o());
      rc(4'h0, 32'h08);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      reset <= 1'h0;
      chk("outs", 32'h0, o());
      rc(4'h4, 32'h78);
      t_drive();
      t_bandgap();
      t_supply();
      t_odd();
      t_reset();
      complete_run();
   end
endmodule
